/* File: prog_link_if.sv */
`timescale 1ns/1ps
// Words held stable by their owner; toggles mark when they are valid
interface prog_link_if;
    logic [3:0]  cmd;
    logic [15:0] operand;
    logic        cmd_tgl;
    logic        done_tgl;
    logic        ack_tgl;
    logic [7:0]  latch;

    modport link (output cmd, operand, cmd_tgl, done_tgl,
                  input  ack_tgl, latch);
    modport ctrl (input  cmd, operand, cmd_tgl, done_tgl,
                  output ack_tgl, latch);
endinterface : prog_link_if

/* File: prog_model.sv */
`timescale 1ns/1ps
// Programmer side: its clock runs only inside a frame
module prog_model (
    output logic      clk_out,
    output logic      dat_out,
    input  wire logic dat_in
);
    logic [7:0] rd_q;
    initial begin
        clk_out = 1'b0; // Clock and data low before entry
        dat_out = 1'b0;
        rd_q    = 8'h00;
    end
    // One instruction, LSb first, data moved after each rise
    task automatic send(input logic [3:0] c, input logic [15:0] op);
        logic [19:0] w;
        logic        rd;
        w  = {op, c};
        rd = (c == 4'h2) || (c[3:2] == 2'b10); // Read-type operand
        for (int i = 0; i < 20; i++) begin
            #17 clk_out = 1'b1; // Off the system clock edges
            // Released line toggles so a stale value cannot pass
            #3 dat_out = (rd && i >= 12) ? ~dat_out : w[i];
            #37 clk_out = 1'b0;
            if (rd && i >= 12) rd_q[i-12] = dat_in;
            #23;
        end
        dat_out = 1'b0;
    endtask : send
endmodule : prog_model

/* File: prog_port_pkg.sv */
package prog_port_pkg;
    localparam int CMD_W     = 4;
    localparam int OPER_W    = 16;
    localparam int BYTE_W    = 8;
    localparam int ADDR_W    = 22;
    localparam int RAM_AW    = 12;
    localparam int CNT_W     = 5;
    localparam int PTR_U_W   = 6;
    localparam int PTR_H_LSB = 8;
    localparam int PTR_U_LSB = 16;

    // Bit counter landmarks within one 20-bit instruction
    localparam logic [4:0] CNT_CMD_LAST = 5'h03;
    localparam logic [4:0] CNT_OPER     = 5'h04;
    localparam logic [4:0] CNT_LOAD     = 5'h0b;
    localparam logic [4:0] CNT_OUT      = 5'h0c;
    localparam logic [4:0] CNT_LAST     = 5'h13;

    // Four-bit commands
    localparam logic [3:0] CMD_CORE      = 4'h0;
    localparam logic [3:0] CMD_SHIFT_LAT = 4'h2;
    localparam logic [3:0] CMD_RD        = 4'h8;
    localparam logic [3:0] CMD_RD_POSTI  = 4'h9;
    localparam logic [3:0] CMD_RD_POSTD  = 4'ha;
    localparam logic [3:0] CMD_RD_PREI   = 4'hb;
    localparam logic [3:0] CMD_WR        = 4'hc;
    localparam logic [3:0] CMD_WR_INC2   = 4'hd;
    localparam logic [3:0] CMD_WR_GO_INC = 4'he;
    localparam logic [3:0] CMD_WR_GO     = 4'hf;

    // Register locations on the core data bus
    localparam logic [11:0] LATCH_OFS = 12'hff5;
    localparam logic [11:0] PTR_L_OFS = 12'hff6;
    localparam logic [11:0] PTR_H_OFS = 12'hff7;
    localparam logic [11:0] PTR_U_OFS = 12'hff8;
    localparam logic [11:0] MWC_OFS   = 12'hfa6;

    // Memory write control field positions
    localparam int MWC_PGD  = 7;
    localparam int MWC_CONFIG_SPACE_SELECT = 6;
    localparam int MWC_FREE = 4;
    localparam int MWC_WRITE_ENABLE_BIT = 2;
    localparam int MWC_WR   = 1;

    localparam logic [21:0] PTR_RST   = 22'h000000;
    localparam logic [21:0] PTR_STEP1 = 22'h000001;
    localparam logic [21:0] PTR_STEP2 = 22'h000002;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;

    typedef enum logic [1:0] {
        OWN_IDLE = 2'b00,
        OWN_DEF  = 2'b01,
        OWN_ALT  = 2'b10
    } owner_t;

    // Commands whose operand ends with eight device-driven bits
    function automatic logic is_read_cmd(input logic [3:0] c);
        return (c == CMD_SHIFT_LAT) || (c[3:2] == 2'b10);
    endfunction : is_read_cmd
endpackage : prog_port_pkg

/* File: program_port.sv */
// Behaviour
// - Pointer is upper, high, low bytes
// - Program mode tri-states unused I/O
// - Low-voltage entry needs enable bit set
// - Low-voltage select pin dedicated in mode
// - Data changes on rise, sampled on fall
// - Instruction: 4-bit command, 16-bit operand
// - Operand: 16 in, or 8 in 8 out
// - Command 0000 executes operand on core
// - Latch shift-out and four table reads
// - Four table writes, some start programming
// - Alternate port works like default port
// - First enable pin wins, other ignored
// - Alternate port cannot change its bit
// - Code memory: bit 7 set, 6 clear
// - No write without prior write enable
// - Erase select erases pointed region
// - Write-start bit launches the sequence
`timescale 1ns/1ps
module program_port (
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    input  wire logic        prog_clock_in,
    input  wire logic        prog_serial_data_in,
    output logic             prog_serial_data_out,
    output logic             prog_serial_data_oe_out,
    input  wire logic        programming_enable_hv_in,
    input  wire logic        programming_enable_vih_in,
    input  wire logic        low_voltage_select_in,
    input  wire logic        alternate_prog_clock_in,
    input  wire logic        alternate_prog_data_in,
    output logic             alternate_prog_data_out,
    output logic             alternate_prog_data_oe_out,
    input  wire logic        alternate_programming_enable_in,
    input  wire logic        low_voltage_enable_bit_in,
    input  wire logic        alternate_port_enable_in,
    input  wire logic [11:0] ram_addr_in,
    input  wire logic        ram_wr_in,
    input  wire logic [7:0]  ram_wdata_in,
    output logic [7:0]       ram_rdata_out,
    output logic [15:0]      core_instr_out,
    output logic             core_instr_valid_out,
    output logic [21:0]      mem_addr_out,
    output logic             mem_rd_out,
    input  wire logic [7:0]  mem_rdata_in,
    output logic             mem_wr_out,
    output logic [15:0]      mem_wdata_out,
    output logic             program_start_out,
    output logic             erase_start_out,
    input  wire logic        mem_done_in,
    output logic             program_memory_select_out,
    output logic             config_space_select_out,
    output logic             io_tristate_out,
    output logic             low_voltage_select_dedicated_out,
    output logic             alt_port_bit_writable_out
);
    import prog_port_pkg::*;

    prog_link_if lnk_def ();
    prog_link_if lnk_alt ();

    owner_t      own_q, own_d;
    logic        lv_q, lv_d;
    logic [1:0]  run_q, run_d;
    logic [7:0]  s1_q, s2_q;
    logic [1:0]  ts1_q, ts2_q, ts3_q;
    logic        sel_alt, ev_cmd, ev_done, lines_def, lines_alt;
    logic [1:0]  tgl_sel;
    logic [3:0]  lk_cmd;
    logic [15:0] lk_oper;

    // One shifter per port, each on the clock of its own pin
    serial_shifter u_def (
        .link_clk_in   (prog_clock_in),
        .link_rst_n_in (reset_n_in & run_q[0]),
        .data_in       (prog_serial_data_in),
        .data_out      (prog_serial_data_out),
        .data_oe_out   (prog_serial_data_oe_out),
        .lnk           (lnk_def.link)
    );
    serial_shifter u_alt (
        .link_clk_in   (alternate_prog_clock_in),
        .link_rst_n_in (reset_n_in & run_q[1]),
        .data_in       (alternate_prog_data_in),
        .data_out      (alternate_prog_data_out),
        .data_oe_out   (alternate_prog_data_oe_out),
        .lnk           (lnk_alt.link)
    );

    // Pin levels pass two flops before any entry decision
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= {alternate_programming_enable_in,
                     alternate_prog_clock_in, alternate_prog_data_in,
                     programming_enable_hv_in, programming_enable_vih_in,
                     low_voltage_select_in, prog_clock_in,
                     prog_serial_data_in};
            s2_q <= s1_q;
        end
    end

    assign lines_def = !s2_q[1] && !s2_q[0];
    assign lines_alt = !s2_q[6] && !s2_q[5];

    // Port ownership: whichever enable arrives first holds the mode
    always_comb begin
        own_d = own_q;
        lv_d  = lv_q;
        unique case (own_q)
            OWN_IDLE: begin
                if (s2_q[4] && lines_def) begin
                    own_d = OWN_DEF;
                    lv_d  = 1'b0;
                end else if (low_voltage_enable_bit_in && s2_q[2] &&
                             s2_q[3] && lines_def) begin
                    own_d = OWN_DEF;
                    lv_d  = 1'b1;
                end else if (alternate_port_enable_in && s2_q[7] &&
                             lines_alt) begin
                    own_d = OWN_ALT;
                    lv_d  = 1'b0;
                end
            end
            OWN_DEF: begin
                // Alternate enable is not looked at while held
                if (lv_q ? !s2_q[3] : !s2_q[4]) begin
                    own_d = OWN_IDLE;
                    lv_d  = 1'b0;
                end
            end
            OWN_ALT: begin
                if (!s2_q[7]) begin
                    own_d = OWN_IDLE;
                end
            end
            default: begin
                own_d = OWN_IDLE;
                lv_d  = 1'b0;
            end
        endcase
        run_d = {own_d == OWN_ALT, own_d == OWN_DEF};
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            own_q <= OWN_IDLE;
            lv_q  <= 1'b0;
            run_q <= 2'b00;
        end else begin
            own_q <= own_d;
            lv_q  <= lv_d;
            run_q <= run_d;
        end
    end

    assign io_tristate_out                  = run_q != 2'b00;
    assign low_voltage_select_dedicated_out = lv_q;
    assign alt_port_bit_writable_out        = run_q[0];

    // Toggles are muxed before the synchroniser; select is static
    assign sel_alt = run_q[1];
    assign tgl_sel = sel_alt ? {lnk_alt.done_tgl, lnk_alt.cmd_tgl}
                             : {lnk_def.done_tgl, lnk_def.cmd_tgl};
    assign lk_cmd  = sel_alt ? lnk_alt.cmd : lnk_def.cmd;
    assign lk_oper = sel_alt ? lnk_alt.operand : lnk_def.operand;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ts1_q <= '0;
            ts2_q <= '0;
            ts3_q <= '0;
        end else begin
            ts1_q <= tgl_sel;
            ts2_q <= ts1_q;
            ts3_q <= ts2_q;
        end
    end

    assign ev_cmd  = (ts2_q[0] ^ ts3_q[0]) && io_tristate_out;
    assign ev_done = (ts2_q[1] ^ ts3_q[1]) && io_tristate_out;

    logic [21:0] ptr_q, ptr_d, addr_q, addr_d;
    logic [7:0]  lat_q, lat_d, rdat_q, rdat_d;
    logic [3:0]  cmd_q, cmd_d;
    logic [15:0] ins_q, ins_d, wdat_q, wdat_d;
    logic        pgd_q, pgd_d, config_space_select_q, config_space_select_d, free_q, free_d;
    logic        write_enable_bit_q, write_enable_bit_d, wr_q, wr_d, ack_q, ack_d;
    logic        insv_q, insv_d, rd_q, rd_d, mwr_q, mwr_d;
    logic        pgo_q, pgo_d, ego_q, ego_d, go;

    // Pointer, latch, memory control and command execution
    always_comb begin
        ptr_d  = ptr_q;
        addr_d = addr_q;
        lat_d  = lat_q;
        cmd_d  = cmd_q;
        ins_d  = ins_q;
        wdat_d = wdat_q;
        pgd_d  = pgd_q;
        config_space_select_d = config_space_select_q;
        free_d = free_q;
        write_enable_bit_d = write_enable_bit_q;
        wr_d   = wr_q;
        ack_d  = ack_q;
        insv_d = 1'b0;
        rd_d   = 1'b0;
        mwr_d  = 1'b0;
        go     = 1'b0;
        if (mem_done_in) begin
            wr_d = 1'b0;
        end
        if (ram_wr_in) begin
            unique case (ram_addr_in)
                LATCH_OFS: lat_d = ram_wdata_in;
                PTR_L_OFS: ptr_d[PTR_H_LSB-1:0] = ram_wdata_in;
                PTR_H_OFS: ptr_d[PTR_U_LSB-1:PTR_H_LSB] = ram_wdata_in;
                PTR_U_OFS: ptr_d[ADDR_W-1:PTR_U_LSB] =
                               ram_wdata_in[PTR_U_W-1:0];
                MWC_OFS: begin
                    pgd_d  = ram_wdata_in[MWC_PGD];
                    config_space_select_d = ram_wdata_in[MWC_CONFIG_SPACE_SELECT];
                    free_d = ram_wdata_in[MWC_FREE];
                    write_enable_bit_d = ram_wdata_in[MWC_WRITE_ENABLE_BIT];
                    // Only an enable already in place lets WR through
                    go = ram_wdata_in[MWC_WR] && write_enable_bit_q && !wr_q;
                end
                default: ;
            endcase
        end
        if (ev_cmd) begin
            cmd_d  = lk_cmd;
            addr_d = ptr_q;
            if (is_read_cmd(lk_cmd) && lk_cmd != CMD_SHIFT_LAT) begin
                rd_d = 1'b1;
                if (lk_cmd == CMD_RD_PREI) begin
                    ptr_d  = ptr_q + PTR_STEP1;
                    addr_d = ptr_q + PTR_STEP1;
                end
            end else begin
                ack_d = ~ack_q;
            end
        end
        // Read data is taken in the strobe cycle; the pointer moves in that same cycle
        if (rd_q) begin
            lat_d = mem_rdata_in;
            ack_d = ~ack_q;
            if (cmd_q == CMD_RD_POSTI) begin
                ptr_d = ptr_q + PTR_STEP1;
            end else if (cmd_q == CMD_RD_POSTD) begin
                ptr_d = ptr_q - PTR_STEP1;
            end
        end
        if (ev_done) begin
            if (cmd_q == CMD_CORE) begin
                ins_d  = lk_oper;
                insv_d = 1'b1;
            end else if (cmd_q[3:2] == 2'b11) begin
                wdat_d = lk_oper;
                addr_d = ptr_q;
                mwr_d  = 1'b1;
                if (cmd_q == CMD_WR_INC2 || cmd_q == CMD_WR_GO_INC) begin
                    ptr_d = ptr_q + PTR_STEP2;
                end
                if (cmd_q == CMD_WR_GO || cmd_q == CMD_WR_GO_INC) begin
                    go = write_enable_bit_q && !wr_q;
                end
            end
        end
        if (go) begin
            wr_d = 1'b1;
        end
        pgo_d = go && !free_d;
        ego_d = go && free_d;
        if (!io_tristate_out) begin
            ack_d = 1'b0;
        end
        unique case (ram_addr_in)
            LATCH_OFS: rdat_d = lat_q;
            PTR_L_OFS: rdat_d = ptr_q[PTR_H_LSB-1:0];
            PTR_H_OFS: rdat_d = ptr_q[PTR_U_LSB-1:PTR_H_LSB];
            PTR_U_OFS: rdat_d = {2'b00, ptr_q[ADDR_W-1:PTR_U_LSB]};
            MWC_OFS:   rdat_d = {pgd_q, config_space_select_q, 1'b0, free_q, 1'b0,
                                 write_enable_bit_q, wr_q, 1'b0};
            default:   rdat_d = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ptr_q  <= PTR_RST;
            addr_q <= PTR_RST;
            lat_q  <= BYTE_ZERO;
            rdat_q <= BYTE_ZERO;
            cmd_q  <= CMD_CORE;
            ins_q  <= '0;
            wdat_q <= '0;
            pgd_q  <= 1'b0;
            config_space_select_q <= 1'b0;
            free_q <= 1'b0;
            write_enable_bit_q <= 1'b0;
            wr_q   <= 1'b0;
            ack_q  <= 1'b0;
            insv_q <= 1'b0;
            rd_q   <= 1'b0;
            mwr_q  <= 1'b0;
            pgo_q  <= 1'b0;
            ego_q  <= 1'b0;
        end else begin
            ptr_q  <= ptr_d;
            addr_q <= addr_d;
            lat_q  <= lat_d;
            rdat_q <= rdat_d;
            cmd_q  <= cmd_d;
            ins_q  <= ins_d;
            wdat_q <= wdat_d;
            pgd_q  <= pgd_d;
            config_space_select_q <= config_space_select_d;
            free_q <= free_d;
            write_enable_bit_q <= write_enable_bit_d;
            wr_q   <= wr_d;
            ack_q  <= ack_d;
            insv_q <= insv_d;
            rd_q   <= rd_d;
            mwr_q  <= mwr_d;
            pgo_q  <= pgo_d;
            ego_q  <= ego_d;
        end
    end

    assign lnk_def.ack_tgl = ack_q;
    assign lnk_def.latch   = lat_q;
    assign lnk_alt.ack_tgl = ack_q;
    assign lnk_alt.latch   = lat_q;

    assign ram_rdata_out             = rdat_q;
    assign core_instr_out            = ins_q;
    assign core_instr_valid_out      = insv_q;
    assign mem_addr_out              = addr_q;
    assign mem_rd_out                = rd_q;
    assign mem_wr_out                = mwr_q;
    assign mem_wdata_out             = wdat_q;
    assign program_start_out         = pgo_q;
    assign erase_start_out           = ego_q;
    assign program_memory_select_out = pgd_q;
    assign config_space_select_out   = config_space_select_q;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    lv_gate_a: assert property ($rose(lv_q) |->
        $past(low_voltage_enable_bit_in) && $past(s2_q[2]))
        else $error("low-voltage mode without enable bit");
    lv_pin_a: assert property (lv_q |->
        low_voltage_select_dedicated_out && io_tristate_out)
        else $error("low-voltage select pin not dedicated");
    hiz_entry_a: assert property (
        $rose(own_q != OWN_IDLE) |-> ##1 io_tristate_out)
        else $error("I/O not released on mode entry");
    owner_hold_a: assert property (
        own_q != OWN_IDLE && $past(own_q) != OWN_IDLE
        |-> own_q == $past(own_q))
        else $error("port owner changed while held");
    alt_bit_a: assert property (
        run_q[1] |-> !alt_port_bit_writable_out)
        else $error("alternate port may write its own bit");
    core_pass_a: assert property (
        ev_done && cmd_q == CMD_CORE |=> core_instr_valid_out &&
        core_instr_out == $past(lk_oper))
        else $error("core instruction not passed");
    pre_inc_a: assert property (
        ev_cmd && lk_cmd == CMD_RD_PREI |=> mem_rd_out &&
        mem_addr_out == $past(ptr_q) + PTR_STEP1)
        else $error("pre-increment read address wrong");
    post_dec_a: assert property (
        rd_q && cmd_q == CMD_RD_POSTD && !ram_wr_in
        |=> ptr_q == $past(ptr_q) - PTR_STEP1)
        else $error("post-decrement missing");
    wr_inc2_a: assert property (
        ev_done && !ram_wr_in &&
        (cmd_q == CMD_WR_INC2 || cmd_q == CMD_WR_GO_INC)
        |=> mem_wr_out && ptr_q == $past(ptr_q) + PTR_STEP2)
        else $error("write post-increment by two missing");
    start_gate_a: assert property (
        (program_start_out || erase_start_out) |-> $past(write_enable_bit_q))
        else $error("write started without prior enable");
    erase_sel_a: assert property (
        erase_start_out |-> free_q && !program_start_out)
        else $error("erase started without erase select");

    core_cov_c: cover property (ev_done && cmd_q == CMD_CORE);
    read_cov_c: cover property (rd_q ##[1:200] ev_done);
    start_cov_c: cover property (program_start_out);
    alt_cov_c: cover property (own_q == OWN_ALT && ev_done);
endmodule : program_port

/* File: serial_shifter.sv */
`timescale 1ns/1ps
module serial_shifter (
    input  wire logic link_clk_in,
    input  wire logic link_rst_n_in,
    input  wire logic data_in,
    output logic      data_out,
    output logic      data_oe_out,
    prog_link_if.link lnk
);
    import prog_port_pkg::*;

    logic [4:0]  cnt_q,  cnt_d;
    logic [3:0]  cmd_q,  cmd_d;
    logic [15:0] oper_q, oper_d;
    logic [7:0]  out_q,  out_d;
    logic        ctgl_q, ctgl_d, dtgl_q, dtgl_d, rdy_q, rdy_d;
    logic        ack_s1_q, ack_s2_q;
    logic        dout_q, dout_d, oe_q, oe_d;

    // Falling-edge capture, LSb first: 4 command bits then operand
    always_comb begin
        cnt_d  = cnt_q + 5'h01;
        cmd_d  = cmd_q;
        oper_d = oper_q;
        out_d  = out_q;
        ctgl_d = ctgl_q;
        dtgl_d = dtgl_q;
        rdy_d  = rdy_q;
        if (cnt_q < CNT_OPER) begin
            cmd_d[cnt_q[1:0]] = data_in;
        end else begin
            oper_d[4'(cnt_q - CNT_OPER)] = data_in;
        end
        if (cnt_q == CNT_CMD_LAST) begin
            ctgl_d = ~ctgl_q;
        end
        // Latch byte must have crossed by now; else the pin stays released
        if (cnt_q == CNT_LOAD) begin
            out_d = lnk.latch;
            rdy_d = (ack_s2_q == ctgl_q);
        end
        if (cnt_q == CNT_LAST) begin
            cnt_d  = '0;
            dtgl_d = ~dtgl_q;
            rdy_d  = 1'b0;
        end
    end

    always_ff @(negedge link_clk_in or negedge link_rst_n_in) begin
        if (!link_rst_n_in) begin
            cnt_q    <= '0;
            cmd_q    <= '0;
            oper_q   <= '0;
            out_q    <= '0;
            ctgl_q   <= 1'b0;
            dtgl_q   <= 1'b0;
            rdy_q    <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            cmd_q    <= cmd_d;
            oper_q   <= oper_d;
            out_q    <= out_d;
            ctgl_q   <= ctgl_d;
            dtgl_q   <= dtgl_d;
            rdy_q    <= rdy_d;
            ack_s1_q <= lnk.ack_tgl;
            ack_s2_q <= ack_s1_q;
        end
    end

    // Drive after the rising edge so the programmer samples on the fall
    always_comb begin
        oe_d   = is_read_cmd(cmd_q) && (cnt_q >= CNT_OUT) && rdy_q;
        dout_d = out_q[3'(cnt_q - CNT_OUT)];
    end

    always_ff @(posedge link_clk_in or negedge link_rst_n_in) begin
        if (!link_rst_n_in) begin
            dout_q <= 1'b0;
            oe_q   <= 1'b0;
        end else begin
            dout_q <= dout_d;
            oe_q   <= oe_d;
        end
    end

    assign data_out     = dout_q;
    assign data_oe_out  = oe_q;
    assign lnk.cmd      = cmd_q;
    assign lnk.operand  = oper_q;
    assign lnk.cmd_tgl  = ctgl_q;
    assign lnk.done_tgl = dtgl_q;

    oe_window_a: assert property (
        @(posedge link_clk_in) disable iff (!link_rst_n_in)
        data_oe_out |-> is_read_cmd(cmd_q) && $past(cnt_q) >= CNT_OUT)
        else $error("serial data driven outside read window");
    frame_len_a: assert property (
        @(negedge link_clk_in) disable iff (!link_rst_n_in)
        $changed(dtgl_q) |-> cnt_q == '0 && $past(cnt_q) == CNT_LAST)
        else $error("instruction not 20 bits long");
endmodule : serial_shifter

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    logic        mclk_in = 1'b0, reset_n_in = 1'b0, hv = 1'b0, vih = 1'b0;
    logic        lvs = 1'b0, lve = 1'b0, alt_en = 1'b0, ape = 1'b0;
    logic        ram_wr = 1'b0, done = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0]  wd = 8'h00, md = 8'h5a, rdata;
    logic        prog_clock, drv, d_out, d_oe, a_out, a_oe, ci_v, m_rd, m_wr;
    logic        p_st, e_st, tri_s, lv_ded, ap_wr, sel7, cfg6;
    logic [15:0] ci, m_wd, ci_q, wd_q;
    logic [21:0] m_a, rd_a_q, wr_a_q, p;
    int          n_mismatch = 0, n_checks = 0, n_pg = 0, n_er = 0;
    wire         prog_serial_data = d_oe ? d_out : (a_oe ? a_out : drv);
    program_port i_dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .prog_clock_in(prog_clock), .prog_serial_data_in(prog_serial_data),
        .prog_serial_data_out(d_out), .prog_serial_data_oe_out(d_oe),
        .programming_enable_hv_in(hv), .programming_enable_vih_in(vih),
        .low_voltage_select_in(lvs), .alternate_prog_clock_in(prog_clock),
        .alternate_prog_data_in(prog_serial_data), .alternate_prog_data_out(a_out),
        .alternate_prog_data_oe_out(a_oe),
        .alternate_programming_enable_in(alt_en),
        .low_voltage_enable_bit_in(lve), .alternate_port_enable_in(ape),
        .ram_addr_in(addr), .ram_wr_in(ram_wr), .ram_wdata_in(wd),
        .ram_rdata_out(rdata), .core_instr_out(ci),
        .core_instr_valid_out(ci_v), .mem_addr_out(m_a), .mem_rd_out(m_rd),
        .mem_rdata_in(md), .mem_wr_out(m_wr), .mem_wdata_out(m_wd),
        .program_start_out(p_st), .erase_start_out(e_st),
        .mem_done_in(done), .program_memory_select_out(sel7),
        .config_space_select_out(cfg6), .io_tristate_out(tri_s),
        .low_voltage_select_dedicated_out(lv_ded),
        .alt_port_bit_writable_out(ap_wr));
    prog_model i_prog (.clk_out(prog_clock), .dat_out(drv), .dat_in(prog_serial_data));
    always #5 mclk_in = ~mclk_in;
    // Keep what each one-cycle strobe carried
    always @(posedge mclk_in) begin
        if (m_rd) rd_a_q <= m_a;
        if (m_wr) wr_a_q <= m_a;
        if (m_wr) wd_q <= m_wd;
        if (ci_v) ci_q <= ci;
        if (p_st) n_pg++;
        if (e_st) n_er++;
    end
    task automatic chk(input logic [21:0] got, input logic [21:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic bw(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk_in) #1 {addr, wd, ram_wr} = {a, d, 1'b1};
        @(posedge mclk_in) #1 ram_wr = 1'b0;
        repeat (2) @(posedge mclk_in);
        #1;
    endtask : bw
    task automatic br(input logic [11:0] a, input logic [7:0] e);
        @(posedge mclk_in) #1 addr = a;
        @(posedge mclk_in) #1 chk(22'(rdata), 22'(e));
    endtask : br
    // Send an instruction, then let the command act in the fast domain
    task automatic go(input logic [3:0] c, input logic [15:0] op);
        i_prog.send(c, op);
        repeat (8) @(posedge mclk_in);
    endtask : go
    task automatic pause;
        repeat (6) @(posedge mclk_in);
        #1;
    endtask : pause
    task automatic give_verdict;
        if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    initial begin
        #200000 n_mismatch++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge mclk_in);
        #1 reset_n_in = 1'b1;
        pause();
        chk(22'(tri_s), 22'h0);
        hv = 1'b1;
        pause();
        chk(22'(tri_s), 22'h1);
        chk(22'(ap_wr), 22'h1);
        bw(12'hff8, 8'hff);
        bw(12'hff7, 8'h12);
        bw(12'hff6, 8'h34);
        br(12'hff8, 8'h3f);
        br(12'hff7, 8'h12);
        br(12'h000, 8'h00);
        p = 22'h3f1234;
        // Four reads: none, post +1, post -1, pre +1
        for (int k = 0; k < 4; k++) begin
            go(4'h8 + 4'(k), 16'h0000);
            chk(rd_a_q, p + 22'(k == 3));
            chk(22'(i_prog.rd_q), 22'h5a);
            p = p + 22'(k == 1) - 22'(k == 2) + 22'(k == 3);
            br(12'hff6, p[7:0]);
        end
        md = 8'ha5;
        go(4'h2, 16'h0000);
        chk(22'(i_prog.rd_q), 22'h5a);
        go(4'h0, 16'h6af6);
        chk(22'(ci_q), 22'h6af6);
        // Four writes: plain, +2, start +2, start
        for (int k = 0; k < 4; k++) begin
            go(4'hc + 4'(k), 16'h3c40 + 16'(k));
            chk(wr_a_q, p);
            chk(22'(wd_q), 22'h3c40 + 22'(k));
            p = p + 22'((k == 1 || k == 2) ? 2 : 0);
        end
        bw(12'hfa6, 8'h82);
        chk(22'(n_pg), 22'h0);
        bw(12'hfa6, 8'h84);
        chk(22'({sel7, cfg6}), 22'h2);
        go(4'hf, 16'h3c44);
        chk(22'(n_pg), 22'h1);
        @(posedge mclk_in) #1 done = 1'b1;
        @(posedge mclk_in) #1 done = 1'b0;
        bw(12'hfa6, 8'h86);
        chk(22'(n_pg), 22'h2);
        @(posedge mclk_in) #1 done = 1'b1;
        @(posedge mclk_in) #1 done = 1'b0;
        bw(12'hfa6, 8'h96);
        chk(22'(n_er * 4 + n_pg), 22'h6);
        {hv, ape, alt_en} = 3'b011;
        pause();
        chk(22'({ap_wr, tri_s}), 22'h1);
        hv = 1'b1;
        go(4'h0, 16'h0e3c);
        chk(22'(ci_q), 22'h0e3c);
        chk(22'(ap_wr), 22'h0);
        {hv, alt_en} = 2'b00;
        pause();
        {lve, lvs, vih} = 3'b111;
        pause();
        chk(22'({lv_ded, tri_s}), 22'h3);
        give_verdict();
    end
endmodule : tb
